/* File: logic/tgc_pkg.sv */
// tgc_pkg: constants shared by the timer gate-control block
// assumes a 32-bit classic wishbone register bus, byte addressed, word aligned
package tgc_pkg;
    // register byte offsets
    localparam logic [7:0] TGC_GATE_CTRL_OFS = 8'h00;
    localparam logic [7:0] TGC_TIMER_CTRL_OFS = 8'h04;
    localparam logic [7:0] TGC_COUNT_OFS = 8'h08;
    localparam logic [7:0] TGC_IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] TGC_IRQ_MASK_OFS = 8'h10;
    // gate control field positions
    localparam int TGC_GE_BIT = 7;
    localparam int TGC_GATE_POLARITY_BIT = 6;
    localparam int TGC_TGL_BIT = 5;
    localparam int TGC_SPM_BIT = 4;
    localparam int TGC_ARM_BIT = 3;
    localparam int TGC_LVL_BIT = 2;
    // timer control field positions
    localparam int TGC_ON_BIT = 0;
    // interrupt status field positions
    localparam int TGC_IRQ_DONE_BIT = 0;
    localparam int TGC_IRQ_OVF_BIT = 1;
    localparam int TGC_IRQ_W = 2;
    // reset values
    localparam logic [7:0] TGC_GATE_CTRL_RST = 8'h00;
    localparam logic [15:0] TGC_COUNT_RST = 16'h0000;
    localparam logic [TGC_IRQ_W-1:0] TGC_IRQ_MASK_RST = 2'h0;
    // single-pulse acquisition states
    typedef enum logic [1:0] {
        TGC_SP_IDLE,
        TGC_SP_WAIT,
        TGC_SP_OPEN
    } tgc_sp_state_e;
endpackage

/* File: logic/tgc_gate_path.sv */
// tgc_gate_path: gate polarity, toggle flip-flop and single-pulse acquisition
// assumes gate_in synchronous to mclk_in; controls come from the register file
`timescale 1ns/10ps
module tgc_gate_path
    import tgc_pkg::*;
(
    input wire logic mclk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic gate_in, // raw gate source
    input wire logic gate_polarity_in, // 1: active high gate
    input wire logic gate_toggle_select_in, // toggle mode
    input wire logic single_pulse_select_in, // single-pulse mode
    input wire logic arm_set_in, // software writes a one to arm
    output logic pulse_armed_flag_out, // acquisition armed
    output logic done_pulse_out, // acquisition completed, one cycle
    output logic gate_level_out // gate as applied to the count pair
);
    logic gate_d_reg;
    logic tgl_reg;
    logic tgl_next;
    tgc_sp_state_e sp_reg;
    tgc_sp_state_e sp_next;
    logic armed_next;
    logic done_next;
    wire logic pol_gate;
    wire logic gate_rise;
    wire logic tgl_gate;
    wire logic tgl_rise;
    wire logic tgl_fall;
    logic tgl_gate_d_reg;

    // polarity turns the gate into an active-high enable
    assign pol_gate = gate_polarity_in ? gate_in : ~gate_in; // RULE_02
    assign gate_rise = gate_in & ~gate_d_reg;
    assign tgl_gate = gate_toggle_select_in ? tgl_reg : pol_gate; // RULE_03
    assign tgl_rise = tgl_gate & ~tgl_gate_d_reg;
    assign tgl_fall = ~tgl_gate & tgl_gate_d_reg;

    // toggle flip-flop flips on every gate rising edge, cleared outside toggle mode
    always_comb begin
        tgl_next = tgl_reg;
        if (!gate_toggle_select_in) begin
            tgl_next = 1'b0; // RULE_03
        end else if (gate_rise) begin
            tgl_next = ~tgl_reg; // RULE_04
        end
    end

    // single pulse: wait for active edge, open for one window, then done
    always_comb begin
        sp_next = sp_reg;
        armed_next = 1'b0;
        done_next = 1'b0;
        unique case (sp_reg)
            TGC_SP_IDLE: begin
                if (single_pulse_select_in && arm_set_in) begin
                    sp_next = TGC_SP_WAIT; // RULE_06
                end
            end
            TGC_SP_WAIT: begin
                if (tgl_rise) begin
                    sp_next = TGC_SP_OPEN;
                end
            end
            TGC_SP_OPEN: begin
                if (tgl_fall) begin
                    sp_next = TGC_SP_IDLE; // RULE_06
                    done_next = 1'b1;
                end
            end
        endcase
        if (!single_pulse_select_in) begin
            sp_next = TGC_SP_IDLE; // RULE_07
            done_next = 1'b0;
        end
        armed_next = (sp_next != TGC_SP_IDLE);
    end

    // state and output registers
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gate_d_reg <= 1'b0;
            tgl_reg <= 1'b0;
            tgl_gate_d_reg <= 1'b0;
            sp_reg <= TGC_SP_IDLE;
            pulse_armed_flag_out <= 1'b0;
            done_pulse_out <= 1'b0;
            gate_level_out <= 1'b0;
        end else begin
            gate_d_reg <= gate_in;
            tgl_reg <= tgl_next;
            tgl_gate_d_reg <= tgl_gate;
            sp_reg <= sp_next;
            pulse_armed_flag_out <= armed_next;
            done_pulse_out <= done_next;
            // single-pulse logic takes over the gate when selected
            gate_level_out <= single_pulse_select_in ? (sp_next == TGC_SP_OPEN) : tgl_gate; // RULE_05
        end
    end
endmodule // tgc_gate_path

/* File: logic/tgc_top.sv */
// tgc_top: timer gate control with a 16-bit count register pair
// assumes a classic wishbone master, 32-bit data, gate input synchronous to mclk_in
// What this block does
// RULE_01: gate enable ignored while timer off; when on and set, gate governs counting
// RULE_02: polarity set counts while gate high; clear counts while gate low
// RULE_03: toggle bit routes gate through flip-flop; clearing it clears the flip-flop
// RULE_04: in toggle mode the flip-flop flips on each gate rising edge
// RULE_05: single-pulse bit hands the gate to acquisition logic; clear disables it
// RULE_06: software arms acquisition by setting the flag; hardware clears it when done
// RULE_07: clearing single-pulse mode clears the armed flag, abandoning acquisition
// RULE_08: gate level status shows the applied gate, independent of gate enable
// RULE_09: gate control bits 7..2 as listed, bits 1-0 read as zero
// RULE_10: timer on with gate enable clear counts every clock
`timescale 1ns/10ps
module tgc_top
    import tgc_pkg::*;
(
    input wire logic mclk_in, // 100 MHz system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic gate_in, // gate source
    input wire logic wb_cyc_in, // wishbone cycle
    input wire logic wb_stb_in, // wishbone strobe
    input wire logic wb_we_in, // wishbone write enable
    input wire logic [7:0] wb_adr_in, // wishbone byte address
    input wire logic [3:0] wb_sel_in, // wishbone byte selects
    input wire logic [31:0] wb_dat_in, // wishbone write data
    output logic [31:0] wb_dat_out, // wishbone read data
    output logic wb_ack_out, // wishbone acknowledge
    output logic wb_err_out, // unmapped address answer
    output logic irq_out, // level interrupt
    output logic count_en_out, // timer counts this cycle
    output logic [15:0] count_register_pair_out // timer count value
);
    logic gate_enable_reg;
    logic gate_polarity_reg;
    logic gate_toggle_select_reg;
    logic single_pulse_select_reg;
    logic timer_on_reg;
    logic [15:0] count_reg;
    logic [TGC_IRQ_W-1:0] irq_stat_reg;
    logic [TGC_IRQ_W-1:0] irq_mask_reg;
    logic [TGC_IRQ_W-1:0] irq_stat_next;
    logic [31:0] rd_data_next;
    logic pulse_armed_flag;
    logic done_pulse;
    logic gate_level_status;
    wire logic req;
    wire logic wr;
    wire logic hit_gc;
    wire logic hit_tc;
    wire logic hit_cnt;
    wire logic hit_st;
    wire logic hit_mk;
    wire logic mapped;
    wire logic arm_set;
    wire logic count_en;
    wire logic overflow;
    wire logic [7:0] gate_ctrl_view;
    wire logic [TGC_IRQ_W-1:0] irq_events;

    // bus decode; one access per request, ack drops the cycle after
    assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
    assign wr = req & wb_we_in & wb_sel_in[0];
    assign hit_gc = (wb_adr_in == TGC_GATE_CTRL_OFS);
    assign hit_tc = (wb_adr_in == TGC_TIMER_CTRL_OFS);
    assign hit_cnt = (wb_adr_in == TGC_COUNT_OFS);
    assign hit_st = (wb_adr_in == TGC_IRQ_STAT_OFS);
    assign hit_mk = (wb_adr_in == TGC_IRQ_MASK_OFS);
    assign mapped = hit_gc | hit_tc | hit_cnt | hit_st | hit_mk;
    assign arm_set = wr & hit_gc & wb_dat_in[TGC_ARM_BIT]; // RULE_06

    // gate control view: status bits live, bits 1-0 zero
    assign gate_ctrl_view = {gate_enable_reg, gate_polarity_reg, gate_toggle_select_reg,
                             single_pulse_select_reg, pulse_armed_flag,
                             gate_level_status, 2'b00}; // RULE_09

    // count qualification
    assign count_en = timer_on_reg & (~gate_enable_reg | gate_level_status); // RULE_01 RULE_10
    assign overflow = count_en & (count_reg == 16'hFFFF);
    assign irq_events = {overflow, done_pulse};

    // gate polarity, toggle and single-pulse logic
    tgc_gate_path u_gate_path (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .gate_in(gate_in),
        .gate_polarity_in(gate_polarity_reg),
        .gate_toggle_select_in(gate_toggle_select_reg),
        .single_pulse_select_in(single_pulse_select_reg),
        .arm_set_in(arm_set),
        .pulse_armed_flag_out(pulse_armed_flag),
        .done_pulse_out(done_pulse),
        .gate_level_out(gate_level_status) // RULE_08
    );

    // sticky status: a new event wins over a write-one clear
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr && hit_st) begin
            irq_stat_next = irq_stat_reg & ~wb_dat_in[TGC_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | irq_events;
    end

    // read mux
    always_comb begin
        rd_data_next = 32'h0000_0000;
        if (hit_gc) begin
            rd_data_next[7:0] = gate_ctrl_view;
        end else if (hit_tc) begin
            rd_data_next[TGC_ON_BIT] = timer_on_reg;
        end else if (hit_cnt) begin
            rd_data_next[15:0] = count_reg;
        end else if (hit_st) begin
            rd_data_next[TGC_IRQ_W-1:0] = irq_stat_reg;
        end else if (hit_mk) begin
            rd_data_next[TGC_IRQ_W-1:0] = irq_mask_reg;
        end
    end

    // bus answer registers
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= req & mapped;
            wb_err_out <= req & ~mapped;
            wb_dat_out <= (req & ~wb_we_in) ? rd_data_next : 32'h0000_0000;
        end
    end

    // gate control fields
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gate_enable_reg <= TGC_GATE_CTRL_RST[TGC_GE_BIT];
            gate_polarity_reg <= TGC_GATE_CTRL_RST[TGC_GATE_POLARITY_BIT];
            gate_toggle_select_reg <= TGC_GATE_CTRL_RST[TGC_TGL_BIT];
            single_pulse_select_reg <= TGC_GATE_CTRL_RST[TGC_SPM_BIT];
        end else if (wr && hit_gc) begin
            gate_enable_reg <= wb_dat_in[TGC_GE_BIT];
            gate_polarity_reg <= wb_dat_in[TGC_GATE_POLARITY_BIT];
            gate_toggle_select_reg <= wb_dat_in[TGC_TGL_BIT];
            single_pulse_select_reg <= wb_dat_in[TGC_SPM_BIT];
        end
    end

    // timer control and mask
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_on_reg <= 1'b0;
            irq_mask_reg <= TGC_IRQ_MASK_RST;
        end else begin
            if (wr && hit_tc) begin
                timer_on_reg <= wb_dat_in[TGC_ON_BIT];
            end
            if (wr && hit_mk) begin
                irq_mask_reg <= wb_dat_in[TGC_IRQ_W-1:0];
            end
        end
    end

    // count register pair: software write loads, otherwise counts when enabled
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= TGC_COUNT_RST;
        end else if (wr && hit_cnt) begin
            count_reg <= wb_dat_in[15:0];
        end else if (count_en) begin
            count_reg <= count_reg + 16'h0001; // RULE_01
        end
    end

    // interrupt status and registered outputs
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat_reg <= '0;
            irq_out <= 1'b0;
            count_en_out <= 1'b0;
            count_register_pair_out <= TGC_COUNT_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_out <= |(irq_stat_next & irq_mask_reg);
            count_en_out <= count_en;
            count_register_pair_out <= (wr && hit_cnt) ? wb_dat_in[15:0]
                                     : (count_en ? count_reg + 16'h0001 : count_reg);
        end
    end
endmodule // tgc_top

/* File: test/tgc_gate_src.sv */
// tgc_gate_src: gate source model, an idle level plus one-shot pulses
// assumes fire_in is a one-cycle request made just after a clock edge
`timescale 1ns/10ps
module tgc_gate_src (
    input wire logic mclk_in, // clock
    input wire logic idle_in, // gate level between pulses
    input wire logic fire_in, // start one pulse
    input wire logic [7:0] len_in, // pulse length in cycles
    output logic gate_out // gate to the block
);
    logic [7:0] left_reg = 8'h00;
    // inverted level for len_in cycles after each request
    always_ff @(posedge mclk_in) begin
        if (fire_in) left_reg <= len_in;
        else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
    end
    assign gate_out = idle_in ^ (left_reg != 8'h00);
endmodule // tgc_gate_src

/* File: test/tgc_top_props.sv */
// tgc_top_props: bus answer and count checks on the ports of tgc_top
// assumes one clock domain; bound onto every tgc_top instance
`timescale 1ns/10ps
module tgc_top_props (
    input wire logic mclk_in, // clock
    input wire logic rst_n_in, // reset, active low
    input wire logic wb_cyc_in, // cycle
    input wire logic wb_stb_in, // strobe
    input wire logic wb_we_in, // write
    input wire logic [7:0] wb_adr_in, // address
    input wire logic [31:0] wb_dat_out, // read data
    input wire logic wb_ack_out, // acknowledge
    input wire logic wb_err_out, // error
    input wire logic count_en_out, // count qualifier
    input wire logic [15:0] count_register_pair_out // count value
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // request decode, masked while an answer stands
    wire req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    wire mapped = (wb_adr_in[1:0] == 2'h0) && (wb_adr_in <= 8'h10);
    wire cnt_wr = req && wb_we_in && (wb_adr_in == 8'h08);
    wire ctl_rd = req && !wb_we_in && (wb_adr_in == 8'h00);
    sequence req_s; req; endsequence
    sequence answer_s; wb_ack_out || wb_err_out; endsequence
    ans_next_a: assert property (req_s |=> answer_s) else $error("no answer after request");
    ans_pulse_a: assert property (answer_s |=> !answer_s) else $error("answer held");
    no_spur_a: assert property (!req |=> !answer_s) else $error("answer without request");
    ans_excl_a: assert property (!(wb_ack_out && wb_err_out)) else $error("ack with err");
    dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("data off");
    err_map_a: assert property (req |=> wb_err_out == !$past(mapped)) else $error("bad err");
    ctl_pad_a: assert property (ctl_rd |=> wb_dat_out[1:0] == 2'h0)
        else $error("low control bits set");
    count_step_a: assert property (!$past(cnt_wr) |->
        count_register_pair_out == 16'($past(count_register_pair_out) + count_en_out))
        else $error("count step wrong");
endmodule // tgc_top_props
bind tgc_top tgc_top_props u_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .wb_err_out(wb_err_out), .count_en_out(count_en_out),
    .count_register_pair_out(count_register_pair_out));

/* File: test/tb_top.sv */
// tb_top: self-checking bench for tgc_top with a gate source model
// assumes the one-cycle wishbone answer and register map of tgc_pkg
`timescale 1ns/10ps
module tb_top
    import tgc_pkg::*;
;
    logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic idle = 1'b0, fire = 1'b0, ack, err, irq, en, gate, e;
    logic [7:0] adr = 8'h00, len = 8'h01, plen;
    logic [31:0] wdat = 32'h0, rdat, dout, v;
    logic [15:0] cnt, n;
    int fails = 0, checks_done = 0, seed = 33293;
    // clock and the two instances
    always #5 mclk = ~mclk;
    tgc_top dut (.mclk_in(mclk), .rst_n_in(rst_n), .gate_in(gate), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
        .wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack), .wb_err_out(err),
        .irq_out(irq), .count_en_out(en), .count_register_pair_out(cnt));
    tgc_gate_src src (.mclk_in(mclk), .idle_in(idle), .fire_in(fire), .len_in(len),
        .gate_out(gate));
    // gate as the count logic sees it: polarity picks the active level
    function automatic logic gate_act(input logic pol, input logic g);
        return pol ? g : ~g;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // one classic cycle, held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1 && err !== 1'b1);
        rdat = dout;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // one gate pulse of random length, then settle
    task automatic pulse();
        plen = 8'h01 + 8'($unsigned($random(seed)) % 6);
        @(posedge mclk);
        len <= plen;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
        chk("ctrl_reset", rdat, {24'h0, TGC_GATE_CTRL_RST[7:3],
            gate_act(TGC_GATE_CTRL_RST[TGC_GATE_POLARITY_BIT], idle), 2'h0});
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", e, 1'b1);
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hFF);
        wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
        chk("ctrl_ones", rdat, 32'hF0);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, TGC_TIMER_CTRL_OFS, {31'h0, i[3]});
            wb(1'b1, TGC_GATE_CTRL_OFS, {24'h0, i[2], i[1], 6'h0});
            idle <= i[0];
            repeat (4) @(posedge mclk);
            chk("count_en", en, i[3] & (~i[2] | gate_act(i[1], i[0])));
            wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
            chk("gate_level", rdat[TGC_LVL_BIT], gate_act(i[1], i[0]));
        end
        $display("test gate matrix done");
        idle <= 1'b0;
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hE0);
        pulse();
        chk("toggle_first", en, 1'b1);
        pulse();
        chk("toggle_second", en, 1'b0);
        pulse();
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hC0);
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hE0);
        repeat (4) @(posedge mclk);
        chk("toggle_clear", en, 1'b0);
        $display("test toggle done");
        wb(1'b1, TGC_IRQ_MASK_OFS, 32'h1);
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hD0);
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hD8);
        wb(1'b1, TGC_COUNT_OFS, 32'h0);
        wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
        chk("armed", rdat[TGC_ARM_BIT], 1'b1);
        pulse();
        n = {8'h00, plen};
        wb(1'b0, TGC_COUNT_OFS, 32'h0);
        chk("window_count", rdat[15:0], n);
        wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
        chk("armed_done", rdat[TGC_ARM_BIT], 1'b0);
        pulse();
        wb(1'b0, TGC_COUNT_OFS, 32'h0);
        chk("no_rearm", rdat[15:0], n);
        chk("irq_on", irq, 1'b1);
        wb(1'b1, TGC_IRQ_MASK_OFS, 32'h0);
        wb(1'b0, TGC_IRQ_STAT_OFS, 32'h0);
        chk("done_status", rdat[TGC_IRQ_DONE_BIT], 1'b1);
        chk("irq_masked", irq, 1'b0);
        wb(1'b1, TGC_IRQ_MASK_OFS, 32'h1);
        wb(1'b1, TGC_IRQ_STAT_OFS, 32'h1);
        wb(1'b0, TGC_IRQ_STAT_OFS, 32'h0);
        chk("done_cleared", rdat[TGC_IRQ_DONE_BIT], 1'b0);
        chk("irq_off", irq, 1'b0);
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hD8);
        wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
        chk("rearmed", rdat[TGC_ARM_BIT], 1'b1);
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hC0);
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'hD0);
        wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
        chk("abandon", rdat[TGC_ARM_BIT], 1'b0);
        $display("test single pulse done");
        // gate enable clear: free count runs over the top and flags it
        wb(1'b1, TGC_GATE_CTRL_OFS, 32'h0);
        wb(1'b1, TGC_COUNT_OFS, 32'hFFFF);
        wb(1'b0, TGC_IRQ_STAT_OFS, 32'h0);
        chk("ovf_status", rdat[TGC_IRQ_OVF_BIT], 1'b1);
        $display("test overflow done");
        wb(1'b1, TGC_TIMER_CTRL_OFS, 32'h0);
        for (int i = 0; i < 20; i++) begin
            v = $random(seed);
            wb(1'b1, TGC_COUNT_OFS, v);
            wb(1'b0, TGC_COUNT_OFS, 32'h0);
            chk("count_load", rdat, {16'h0, v[15:0]});
            chk("count_pins", {16'h0, cnt}, {16'h0, v[15:0]});
            wb(1'b1, TGC_GATE_CTRL_OFS, v & 32'hF0);
            wb(1'b0, TGC_GATE_CTRL_OFS, 32'h0);
            chk("ctrl_rw", rdat & 32'hFFFFFFFB, v & 32'hF0);
        end
        $display("test random access done");
        give_verdict();
    end
endmodule // tb_top
